// ### design/twu_pkg.sv
package twu_pkg;
  // register byte offsets
  localparam logic [5:0] TWU_OFS_COMP0 = 6'h00;
  localparam logic [5:0] TWU_OFS_MASK0 = 6'h04;
  localparam logic [5:0] TWU_OFS_FCT0 = 6'h08;
  localparam logic [5:0] TWU_OFS_COMP1 = 6'h10;
  localparam logic [5:0] TWU_OFS_MASK1 = 6'h14;
  localparam logic [5:0] TWU_OFS_FCT1 = 6'h18;
  localparam logic [5:0] TWU_OFS_INT_STATUS = 6'h20;
  localparam logic [5:0] TWU_OFS_INT_MASK = 6'h24;
  // function control field positions
  localparam int TWU_FUNC_LSB = 0;
  localparam int TWU_DCE_BIT = 8;
  localparam int TWU_SIZE_LSB = 10;
  localparam int TWU_LSEL_BIT = 12;
  localparam int TWU_HIT_BIT = 24;
  // interrupt status bit positions
  localparam int TWU_INT_HIT0_BIT = 0;
  localparam int TWU_INT_HIT1_BIT = 1;
  // reset values
  localparam logic [31:0] TWU_COMP_RESET = 32'h0000_0000;
  localparam logic [4:0] TWU_MASK_RESET = 5'h00;
  localparam logic [3:0] TWU_FUNC_RESET = 4'h0;
  localparam logic [1:0] TWU_SIZE_RESET = 2'h0;
  localparam logic [1:0] TWU_INT_RESET = 2'h0;
  // largest address ignore mask
  localparam logic [4:0] TWU_MASK_MAX = 5'h18;
  // action encodings
  localparam logic [3:0] TWU_ACT_OFF = 4'h0;
  localparam logic [3:0] TWU_ACT_FETCH = 4'h4;
  localparam logic [3:0] TWU_ACT_READ = 4'h5;
  localparam logic [3:0] TWU_ACT_WRITE = 4'h6;
  localparam logic [3:0] TWU_ACT_RDWR = 4'h7;
  // data compare sizes
  localparam logic [1:0] TWU_SIZE_BYTE = 2'h0;
  localparam logic [1:0] TWU_SIZE_HALF = 2'h1;
  localparam logic [1:0] TWU_SIZE_WORD = 2'h2;
endpackage

// ### design/twu_addr_cmp.sv
`timescale 1ns/10ps
module twu_addr_cmp
  import twu_pkg::*;
(
  input wire logic [31:0] ref_in, // reference address
  input wire logic [4:0] mask_in, // ignored low address bits
  input wire logic fetch_watch_in, // comparator watches fetches
  input wire logic [31:0] addr_in, // observed address
  output logic match_out // address match
);
  logic [31:0] ignore_bits;
  logic [31:0] care_bits;

  // zero mask on a fetch watch still drops bit 0
  assign ignore_bits = (mask_in == 5'h00) ? {31'h0, fetch_watch_in} :
                       ((32'h0000_0001 << mask_in) - 32'h0000_0001);
  assign care_bits = ~ignore_bits;
  assign match_out = ((addr_in ^ ref_in) & care_bits) == 32'h0000_0000;
endmodule

// ### design/twu_data_cmp.sv
`timescale 1ns/10ps
module twu_data_cmp
  import twu_pkg::*;
(
  input wire logic [31:0] ref_in, // replicated reference value
  input wire logic [1:0] size_in, // configured compare size
  input wire logic [1:0] bus_size_in, // size of observed transfer
  input wire logic [1:0] lane_in, // low address bits of transfer
  input wire logic [31:0] data_in, // observed data
  output logic match_out // data match
);
  logic [31:0] diff;
  logic byte_eq;
  logic half_eq;
  logic word_eq;
  logic size_eq;

  assign diff = data_in ^ ref_in;
  assign byte_eq = diff[{lane_in, 3'h0} +: 8] == 8'h00;
  assign half_eq = diff[{lane_in[1], 4'h0} +: 16] == 16'h0000;
  assign word_eq = diff == 32'h0000_0000;
  assign size_eq = bus_size_in == size_in;
  assign match_out = size_eq & ((size_in == TWU_SIZE_BYTE) ? byte_eq :
                                (size_in == TWU_SIZE_HALF) ? half_eq :
                                (size_in == TWU_SIZE_WORD) ? word_eq : 1'b0);
endmodule

// ### design/twu_top.sv
// Summary of operation
// [R01] link select holds only zero or one
// [R02] link select picks linked address comparator
// [R03] software sets link select for data/address pair
// [R04] size field picks byte, halfword or word
// [R05] software never writes size code three
// [R06] data enable picks data or address compare
// [R07] comparator 0 both kinds, comparator 1 address
// [R08] action codes off, fetch, read, write, both
// [R09] comparator 1 uses the same action codes
// [R10] software writes only the five action codes
// [R11] linked mode: software zeroes comparator 1 action
// [R12] linked mode honours the comparator 1 mask
// [R13] comparator 1 data fields read zero, ignore writes
// [R14] hit flag sticky, cleared by register read
// [R15] reserved bits read as zero
// [R16] comparator 0 hit by mode and link
// [R17] software replicates narrow reference across lanes
// [R18] compare in transfer cycle, flag next edge
//
// Chosen here: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
module twu_top
  import twu_pkg::*;
(
  input wire logic ref_clk_in, // 250 MHz clock
  input wire logic reset_n_in, // async reset, active low
  input wire logic [5:0] avs_address_in, // register byte address
  input wire logic avs_read_in, // read request
  input wire logic avs_write_in, // write request
  input wire logic [31:0] avs_writedata_in, // write data
  input wire logic [3:0] avs_byteenable_in, // write byte lanes
  output logic [31:0] avs_readdata_out, // read data
  output logic avs_waitrequest_out, // stall request
  input wire logic bus_valid_in, // observed transfer present
  input wire logic [31:0] bus_addr_in, // transfer address
  input wire logic [31:0] bus_data_in, // transfer data
  input wire logic bus_fetch_in, // transfer is instruction fetch
  input wire logic bus_write_in, // data transfer is a write
  input wire logic [1:0] bus_size_in, // 0 byte, 1 half, 2 word
  output logic irq_out // level interrupt
);
  // access type against action code
  function automatic logic action_hit(input logic [3:0] act, input logic fetch,
                                      input logic wr);
    logic hit;
    hit = 1'b0;
    case (act) // [R08] [R09]
      TWU_ACT_FETCH: hit = fetch;
      TWU_ACT_READ: hit = ~fetch & ~wr;
      TWU_ACT_WRITE: hit = ~fetch & wr;
      TWU_ACT_RDWR: hit = ~fetch;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // byte-lane merge of a write
  function automatic logic [31:0] lane_merge(input logic [31:0] old_val,
                                             input logic [31:0] new_val,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_val[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // mask write clamped to the largest mask
  function automatic logic [4:0] mask_clamp(input logic [31:0] wd);
    logic [4:0] m;
    m = (wd[4:0] > TWU_MASK_MAX) ? TWU_MASK_MAX : wd[4:0];
    return m;
  endfunction

  logic [31:0] comp0_reg;
  logic [31:0] comp0_next;
  logic [31:0] comp1_reg;
  logic [31:0] comp1_next;
  logic [4:0] mask0_reg;
  logic [4:0] mask0_next;
  logic [4:0] mask1_reg;
  logic [4:0] mask1_next;
  logic [3:0] func0_reg;
  logic [3:0] func0_next;
  logic dce0_reg;
  logic dce0_next;
  logic [1:0] size0_reg;
  logic [1:0] size0_next;
  logic lsel0_reg;
  logic lsel0_next;
  logic [3:0] func1_reg;
  logic [3:0] func1_next;
  logic hit0_reg;
  logic hit0_next;
  logic hit1_reg;
  logic hit1_next;
  logic [1:0] int_status_reg;
  logic [1:0] int_status_next;
  logic [1:0] int_mask_reg;
  logic [1:0] int_mask_next;
  logic ack_reg;
  logic ack_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // bus handshake
  wire req = avs_read_in | avs_write_in;
  wire capture = req & ~ack_reg;
  wire accept = req & ack_reg;
  wire wr_acc = accept & avs_write_in;
  wire rd_cap = capture & avs_read_in;
  wire [3:0] be = avs_byteenable_in;
  wire [31:0] wd = avs_writedata_in;

  // address decode
  wire sel_comp0 = avs_address_in == TWU_OFS_COMP0;
  wire sel_mask0 = avs_address_in == TWU_OFS_MASK0;
  wire sel_fct0 = avs_address_in == TWU_OFS_FCT0;
  wire sel_comp1 = avs_address_in == TWU_OFS_COMP1;
  wire sel_mask1 = avs_address_in == TWU_OFS_MASK1;
  wire sel_fct1 = avs_address_in == TWU_OFS_FCT1;
  wire sel_ists = avs_address_in == TWU_OFS_INT_STATUS;
  wire sel_imsk = avs_address_in == TWU_OFS_INT_MASK;

  // comparators
  wire fetch_watch0 = func0_reg == TWU_ACT_FETCH;
  wire fetch_watch1 = func1_reg == TWU_ACT_FETCH;
  wire addr0_match;
  wire addr1_match;
  wire data0_match;

  twu_addr_cmp u_addr0 (
    .ref_in(comp0_reg),
    .mask_in(mask0_reg),
    .fetch_watch_in(fetch_watch0),
    .addr_in(bus_addr_in),
    .match_out(addr0_match)
  );

  // [R12] comparator 1 keeps its own mask when linked
  twu_addr_cmp u_addr1 (
    .ref_in(comp1_reg),
    .mask_in(mask1_reg),
    .fetch_watch_in(fetch_watch1),
    .addr_in(bus_addr_in),
    .match_out(addr1_match)
  );

  // [R04] [R07] only comparator 0 has a data compare
  twu_data_cmp u_data0 (
    .ref_in(comp0_reg),
    .size_in(size0_reg),
    .bus_size_in(bus_size_in),
    .lane_in(bus_addr_in[1:0]),
    .data_in(bus_data_in),
    .match_out(data0_match)
  );

  // [R18] evaluated while the transfer is presented
  wire type0 = bus_valid_in & action_hit(func0_reg, bus_fetch_in, bus_write_in);
  wire type1 = bus_valid_in & action_hit(func1_reg, bus_fetch_in, bus_write_in);
  // [R02] linked address comes from comparator 1 when selected
  wire link_ok = lsel0_reg ? addr1_match : 1'b1;
  // [R06] [R16]
  wire event0 = type0 & (dce0_reg ? (data0_match & link_ok) : addr0_match);
  // linked data compare also qualifies when comparator 1 action is off
  wire event1 = type1 & addr1_match;

  // register write paths, writes land at the accepting edge
  assign comp0_next = (wr_acc & sel_comp0) ? lane_merge(comp0_reg, wd, be) : comp0_reg;
  assign comp1_next = (wr_acc & sel_comp1) ? lane_merge(comp1_reg, wd, be) : comp1_reg;
  assign mask0_next = (wr_acc & sel_mask0 & be[0]) ? mask_clamp(wd) : mask0_reg;
  assign mask1_next = (wr_acc & sel_mask1 & be[0]) ? mask_clamp(wd) : mask1_reg;
  assign func0_next = (wr_acc & sel_fct0 & be[0]) ? wd[TWU_FUNC_LSB +: 4] : func0_reg;
  assign dce0_next = (wr_acc & sel_fct0 & be[1]) ? wd[TWU_DCE_BIT] : dce0_reg;
  assign size0_next = (wr_acc & sel_fct0 & be[1]) ? wd[TWU_SIZE_LSB +: 2] : size0_reg;
  // [R01] only the low bit of the select field is stored
  assign lsel0_next = (wr_acc & sel_fct0 & be[1]) ? wd[TWU_LSEL_BIT] : lsel0_reg;
  // [R13] comparator 1 keeps only its action field
  assign func1_next = (wr_acc & sel_fct1 & be[0]) ? wd[TWU_FUNC_LSB +: 4] : func1_reg;
  assign int_mask_next = (wr_acc & sel_imsk & be[0]) ? wd[1:0] : int_mask_reg;

  // [R14] a read clears, a new hit in the same cycle wins
  assign hit0_next = event0 | (hit0_reg & ~(rd_cap & sel_fct0));
  assign hit1_next = event1 | (hit1_reg & ~(rd_cap & sel_fct1));

  // sticky status, write one to clear, set wins
  wire [1:0] ev_vec = {event1, event0};
  wire [1:0] w1c = (wr_acc & sel_ists & be[0]) ? wd[1:0] : 2'h0;
  assign int_status_next = ev_vec | (int_status_reg & ~w1c);

  // read data images
  wire [31:0] fct0_img = (32'(hit0_reg) << TWU_HIT_BIT) |
                         (32'(lsel0_reg) << TWU_LSEL_BIT) |
                         (32'(size0_reg) << TWU_SIZE_LSB) |
                         (32'(dce0_reg) << TWU_DCE_BIT) |
                         (32'(func0_reg) << TWU_FUNC_LSB); // [R15]
  wire [31:0] fct1_img = (32'(hit1_reg) << TWU_HIT_BIT) |
                         (32'(func1_reg) << TWU_FUNC_LSB); // [R13] [R15]
  wire [31:0] rd_mux = sel_comp0 ? comp0_reg :
                       sel_mask0 ? 32'(mask0_reg) :
                       sel_fct0 ? fct0_img :
                       sel_comp1 ? comp1_reg :
                       sel_mask1 ? 32'(mask1_reg) :
                       sel_fct1 ? fct1_img :
                       sel_ists ? 32'(int_status_reg) :
                       sel_imsk ? 32'(int_mask_reg) : 32'h0000_0000;
  assign rdata_next = rd_cap ? rd_mux : rdata_reg;
  assign ack_next = capture;

  assign avs_waitrequest_out = capture;
  assign avs_readdata_out = rdata_reg;
  assign irq_out = |(int_status_reg & int_mask_reg);

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      comp0_reg <= TWU_COMP_RESET;
      comp1_reg <= TWU_COMP_RESET;
      mask0_reg <= TWU_MASK_RESET;
      mask1_reg <= TWU_MASK_RESET;
    end else begin
      comp0_reg <= comp0_next;
      comp1_reg <= comp1_next;
      mask0_reg <= mask0_next;
      mask1_reg <= mask1_next;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      func0_reg <= TWU_FUNC_RESET;
      dce0_reg <= 1'b0;
      size0_reg <= TWU_SIZE_RESET;
      lsel0_reg <= 1'b0;
      func1_reg <= TWU_FUNC_RESET;
    end else begin
      func0_reg <= func0_next;
      dce0_reg <= dce0_next;
      size0_reg <= size0_next;
      lsel0_reg <= lsel0_next;
      func1_reg <= func1_next;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      hit0_reg <= 1'b0;
      hit1_reg <= 1'b0;
    end else begin
      hit0_reg <= hit0_next; // [R18]
      hit1_reg <= hit1_next; // [R18]
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      int_status_reg <= TWU_INT_RESET;
      int_mask_reg <= TWU_INT_RESET;
    end else begin
      int_status_reg <= int_status_next;
      int_mask_reg <= int_mask_next;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      ack_reg <= ack_next;
      rdata_reg <= rdata_next;
    end
  end
endmodule

// ### test/twu_top_asserts.sv
`timescale 1ns/10ps
module twu_top_asserts
  import twu_pkg::*;
(
  input wire logic ref_clk_in, // clock
  input wire logic reset_n_in, // async reset
  input wire logic [5:0] avs_address_in, // address
  input wire logic avs_read_in, // read
  input wire logic avs_write_in, // write
  input wire logic [31:0] avs_readdata_out, // read data
  input wire logic avs_waitrequest_out, // stall
  input wire logic bus_valid_in, // watched transfer
  input wire logic irq_out // interrupt
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic seen_reg;
  wire capture0 = avs_read_in && avs_waitrequest_out && avs_address_in == TWU_OFS_FCT0;
  wire rd_done = avs_read_in && !avs_waitrequest_out;
  wire mapped = avs_address_in inside {6'h00, 6'h04, 6'h08, 6'h10, 6'h14, 6'h18, 6'h20, 6'h24};
  // any transfer since the last flag snapshot
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seen_reg <= 1'b0;
    end else begin
      seen_reg <= bus_valid_in || (seen_reg && !capture0);
    end
  end
  sequence s_one_wait;
    avs_waitrequest_out ##1 !avs_waitrequest_out;
  endsequence
  AST_RD_WAIT: assert property ($rose(avs_read_in) |-> s_one_wait)
    else $error("read wait not one cycle");
  AST_WR_WAIT: assert property ($rose(avs_write_in) |-> s_one_wait)
    else $error("write wait not one cycle");
  AST_IDLE_NOWAIT: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
    else $error("stall without request");
  AST_UNMAPPED_ZERO: assert property (rd_done && !mapped |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  AST_FCT0_RSVD: assert property (
    rd_done && avs_address_in == TWU_OFS_FCT0 |-> (avs_readdata_out & 32'hFEFF_E2F0) == 32'h0)
    else $error("function 0 reserved bits set");
  AST_FCT1_RAZ: assert property (
    rd_done && avs_address_in == TWU_OFS_FCT1 |-> (avs_readdata_out & 32'hFEFF_FFF0) == 32'h0)
    else $error("function 1 unsupported bits set");
  AST_HIT_CAUSE: assert property (
    rd_done && avs_address_in == TWU_OFS_FCT0 && avs_readdata_out[24] |-> $past(seen_reg))
    else $error("hit flag without transfer");
  AST_IRQ_RISE: assert property ($rose(irq_out) |-> $past(bus_valid_in) || $past(avs_write_in))
    else $error("interrupt rose without cause");
  AST_IRQ_FALL: assert property ($fell(irq_out) |-> $past(avs_write_in))
    else $error("interrupt fell without write");
endmodule
bind twu_top twu_top_asserts i_chk (
  .ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in),
  .avs_address_in(avs_address_in),
  .avs_read_in(avs_read_in),
  .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out),
  .avs_waitrequest_out(avs_waitrequest_out),
  .bus_valid_in(bus_valid_in),
  .irq_out(irq_out)
);

// ### test/twu_core_model.sv
`timescale 1ns/10ps
module twu_core_model (
  input wire logic clk_in, // bench clock
  output logic valid_out, // transfer present
  output logic [31:0] addr_out, // address
  output logic [31:0] data_out, // data
  output logic fetch_out, // instruction fetch
  output logic write_out, // data write
  output logic [1:0] size_out // transfer size
);
  initial begin
    valid_out = 1'b0;
    addr_out = 32'h0;
    data_out = 32'h0;
    fetch_out = 1'b0;
    write_out = 1'b0;
    size_out = 2'h0;
  end
  // one transfer, then idle address and data lines show inverted values
  task automatic xfer(input logic [31:0] a, d, input logic f, w, input logic [1:0] s);
    @(posedge clk_in);
    valid_out <= 1'b1;
    addr_out <= a;
    data_out <= d;
    fetch_out <= f;
    write_out <= w;
    size_out <= s;
    @(posedge clk_in);
    valid_out <= 1'b0;
    addr_out <= ~a;
    data_out <= ~d;
  endtask
endmodule

// ### test/testbench.sv
`timescale 1ns/10ps
module testbench
  import twu_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [5:0] addr = 6'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic wreq, irq, bv, bf, bw;
  logic [31:0] ba, bd;
  logic [1:0] bs;
  int errors = 0;
  int total_checks = 0;
  twu_top i_dut (.ref_clk_in(clk), .reset_n_in(rst_n), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(wreq),
    .bus_valid_in(bv), .bus_addr_in(ba), .bus_data_in(bd), .bus_fetch_in(bf),
    .bus_write_in(bw), .bus_size_in(bs), .irq_out(irq));
  twu_core_model i_core (.clk_in(clk), .valid_out(bv), .addr_out(ba), .data_out(bd),
    .fetch_out(bf), .write_out(bw), .size_out(bs));
  initial begin
    forever #2 clk = ~clk;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic fail(input string m);
    errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task automatic chk_word(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) fail($sformatf("read %h expected %h", got, exp));
  endtask
  task automatic chk_irq(input logic e);
    @(negedge clk);
    total_checks++;
    if (irq !== e) fail("interrupt level");
  endtask
  task automatic access(input logic w, input logic [5:0] a, input logic [31:0] d,
                        output logic [31:0] q);
    int n;
    logic stall;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= d;
    for (n = 0; n < 20; n++) begin
      @(negedge clk);
      stall = wreq;
      q = rdata;
      @(posedge clk);
      if (!stall) break;
    end
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 20) begin
      fail("no bus answer");
      give_verdict();
    end
  endtask
  task automatic wreg(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    access(1'b1, a, d, q);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    logic [31:0] q;
    access(1'b0, a, 32'h0, q);
    chk_word(q, e);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 16; i++) rchk(6'(i * 4), 32'h0);
    rchk(6'h09, 32'h0);
  endtask
  task automatic t_fields();
    wreg(TWU_OFS_FCT0, 32'hFFFF_F9F7);
    rchk(TWU_OFS_FCT0, 32'h0000_1907);
    wreg(TWU_OFS_FCT1, 32'hFFFF_F9F7);
    rchk(TWU_OFS_FCT1, 32'h0000_0007);
  endtask
  task automatic t_actions();
    logic [3:0] acts [5] = '{TWU_ACT_OFF, TWU_ACT_FETCH, TWU_ACT_READ, TWU_ACT_WRITE,
                             TWU_ACT_RDWR};
    logic [2:0] hits [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h6};
    wreg(TWU_OFS_COMP0, 32'h1000_0040);
    wreg(TWU_OFS_COMP1, 32'h1000_0040);
    for (int i = 0; i < 5; i++) begin
      wreg(TWU_OFS_FCT0, {28'h0, acts[i]});
      wreg(TWU_OFS_FCT1, {28'h0, acts[i]});
      for (int k = 0; k < 3; k++) begin
        i_core.xfer(32'h1000_0040, 32'h0, k == 0, k == 2, 2'h2);
        rchk(TWU_OFS_FCT0, {7'h0, hits[i][k], 20'h0, acts[i]});
        rchk(TWU_OFS_FCT1, {7'h0, hits[i][k], 20'h0, acts[i]});
      end
    end
    i_core.xfer(32'h1000_0044, 32'h0, 1'b0, 1'b1, 2'h2);
    rchk(TWU_OFS_FCT1, 32'h0000_0007);
    i_core.xfer(32'h1000_0040, 32'h0, 1'b0, 1'b0, 2'h2);
    rchk(TWU_OFS_FCT1, 32'h0100_0007);
    rchk(TWU_OFS_FCT1, 32'h0000_0007);
  endtask
  task automatic t_data();
    logic [31:0] f;
    rchk(TWU_OFS_FCT0, 32'h0100_0007);
    wreg(TWU_OFS_COMP0, 32'hA5A5_A5A5);
    wreg(TWU_OFS_FCT1, 32'h0);
    for (int s = 0; s < 3; s++) begin
      f = {19'h0, 1'b0, 2'(s), 1'b0, 1'b1, 4'h0, TWU_ACT_RDWR};
      wreg(TWU_OFS_FCT0, f);
      i_core.xfer(32'h3000_0003, 32'hA5A5_A5A5, 1'b0, 1'b1, 2'(s));
      rchk(TWU_OFS_FCT0, f | 32'h0100_0000);
      i_core.xfer(32'h3000_0003, 32'h5A5A_5A5A, 1'b0, 1'b0, 2'(s));
      rchk(TWU_OFS_FCT0, f);
      i_core.xfer(32'h3000_0003, 32'hA5A5_A5A5, 1'b0, 1'b1, 2'(s + 1));
      rchk(TWU_OFS_FCT0, f);
    end
  endtask
  task automatic t_linked();
    wreg(TWU_OFS_COMP1, 32'h2000_0000);
    wreg(TWU_OFS_MASK1, 32'h0000_0008);
    wreg(TWU_OFS_FCT1, 32'h0);
    wreg(TWU_OFS_FCT0, 32'h0000_1107);
    i_core.xfer(32'h2000_00F3, 32'hA5A5_A5A5, 1'b0, 1'b1, 2'h0);
    rchk(TWU_OFS_FCT0, 32'h0100_1107);
    i_core.xfer(32'h2000_0103, 32'hA5A5_A5A5, 1'b0, 1'b1, 2'h0);
    rchk(TWU_OFS_FCT0, 32'h0000_1107);
    rchk(TWU_OFS_FCT1, 32'h0);
  endtask
  task automatic t_irq();
    wreg(TWU_OFS_INT_MASK, 32'h3);
    wreg(TWU_OFS_INT_STATUS, 32'h3);
    chk_irq(1'b0);
    wreg(TWU_OFS_FCT1, {28'h0, TWU_ACT_WRITE});
    i_core.xfer(32'h2000_0000, 32'h0, 1'b0, 1'b1, 2'h2);
    rchk(TWU_OFS_INT_STATUS, 32'h2);
    chk_irq(1'b1);
    wreg(TWU_OFS_INT_MASK, 32'h1);
    chk_irq(1'b0);
    wreg(TWU_OFS_INT_MASK, 32'h2);
    chk_irq(1'b1);
    wreg(TWU_OFS_INT_STATUS, 32'h2);
    chk_irq(1'b0);
    rchk(TWU_OFS_INT_STATUS, 32'h0);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_fields();
    t_actions();
    t_data();
    t_linked();
    t_irq();
    give_verdict();
  end
endmodule
